// file: host_cfg_model.sv
// Host bridge model that issues configuration cycles
`timescale 1ns/1ps

module host_cfg_model (
    // Clock
    input  wire logic        mclk_i,
    // Configuration access
    output logic             cfg_req_o,
    output logic             cfg_we_o,
    output logic      [7:0]  cfg_addr_o,
    output logic      [3:0]  cfg_be_o,
    output logic      [31:0] cfg_wdata_o,
    input  wire logic        cfg_ack_i,
    input  wire logic [31:0] cfg_rdata_i
);
    // Idle lines carry a pattern, never a stale value
    initial begin
        cfg_req_o   = 1'b0;
        cfg_we_o    = 1'b0;
        cfg_addr_o  = 8'hA5;
        cfg_be_o    = 4'h0;
        cfg_wdata_o = 32'h5A5A_A5A5;
    end

    // One access: request for one edge, then a bounded wait for the answer
    task automatic access(input logic we, input logic [7:0] addr,
                          input logic [3:0] be, input logic [31:0] wdata,
                          output logic [31:0] rdata, output logic ok);
        int n;
        ok = 1'b0;
        rdata = 32'h0000_0000;
        @(posedge mclk_i);
        #1;
        cfg_req_o = 1'b1;
        cfg_we_o = we;
        cfg_addr_o = addr;
        cfg_be_o = be;
        cfg_wdata_o = wdata;
        @(posedge mclk_i);
        #1;
        // Released lines turn over so a stale value cannot pass
        cfg_req_o = 1'b0;
        cfg_we_o = ~we;
        cfg_addr_o = ~addr;
        cfg_be_o = ~be;
        cfg_wdata_o = ~wdata;
        for (n = 0; n < 4 && !ok; n++) begin
            if (cfg_ack_i === 1'b1) begin
                ok = 1'b1;
                rdata = cfg_rdata_i;
            end else begin
                @(posedge mclk_i);
                #1;
            end
        end
    endtask
endmodule

// file: pci_command_status_regs.sv
// Command and status words of the configuration header
//
// Contract
// [R01] Command bits 15:10 read zero; writes to them are ignored.
// [R02] Fast back-to-back enable reads zero; no fast back-to-back cycles.
// [R03] System-error enable writable; error pin driven only while set.
// [R04] Stepping control reads zero; no stepping performed.
// [R05] Parity response enable writable; parity pin driven only while set.
// [R06] Palette snoop enable reads zero.
// [R07] Write-invalidate enable picks invalidate or plain memory write.
// [R08] Special cycles ignored; special cycle enable reads zero.
// [R09] Master requests pass only while bus master enable is set.
// [R10] Memory cycles claimed only while memory response enable is set.
// [R11] I/O space enable reads zero; I/O cycles never claimed.
// [R12] Detected parity flag set on any parity error, enable or not.
// [R13] Signalled system error flag set whenever the error pin asserts.
// [R14] Received master abort flag set unless transaction was special.
// [R15] Received target abort flag set on target-abort of own cycle.
// [R16] Signalled target abort flag set when device target-aborts.
// [R17] Device-select timing field reads 01, medium.
// [R18] Master data parity flag set by standard master parity rules.
// [R19] High-frequency capable bit reads zero.
// [R20] Capability list bit reads one when the list pointer exists.
// [R21] Error flags clear only by writing one; other writes no effect.
`timescale 1ns/1ps

module pci_command_status_regs #(
    parameter bit CAP_LIST = 1'b1
) (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // Configuration access
    input  wire logic        cfg_req_i,
    input  wire logic        cfg_we_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    output logic             cfg_ack_o,
    output logic      [31:0] cfg_rdata_o,
    // Bus events from the interface logic
    input  wire logic        addr_parity_err_i,
    input  wire logic        data_parity_err_i,
    input  wire logic        master_rd_parity_i,
    input  wire logic        master_perr_seen_i,
    input  wire logic        master_abort_i,
    input  wire logic        special_cycle_i,
    input  wire logic        target_abort_rcvd_i,
    input  wire logic        target_abort_sig_i,
    // Master and target gating
    input  wire logic        master_req_i,
    input  wire logic        mem_hit_i,
    output logic             master_req_o,
    output logic      [3:0]  master_write_cmd_o,
    output logic             mem_claim_o,
    output logic             bus_master_enable_o,
    // Open-drain error pins
    output logic             system_error_pin_n_o,
    output logic             system_error_pin_n_oe_o,
    output logic             parity_error_pin_n_o,
    output logic             parity_error_pin_n_oe_o
);

    typedef struct packed {
        logic        se;
        logic        pe;
        logic        mwi;
        logic        bm;
        logic        mem;
        logic        ack;
        logic [31:0] rdata;
        logic        serr_oe;
        logic        perr_oe;
        logic        mclaim;
        logic        mreq;
        logic [3:0]  wcmd;
    } regs_t;

    regs_t                            r_q;
    regs_t                            r_d;
    logic                             hit;
    logic                             wr;
    logic [15:0]                      cmd_rd;
    logic [15:0]                      stat_rd;
    logic [15:0]                      ctrl_lane;
    logic [15:0]                      clr16;
    logic [pci_cs_pkg::NUM_FLAGS-1:0] flag_set;
    logic [pci_cs_pkg::NUM_FLAGS-1:0] flag_clr;
    logic [pci_cs_pkg::NUM_FLAGS-1:0] flags;
    logic                             serr_fire;
    logic                             perr_fire;

    // Access decode; both words share one dword, split by byte lanes
    assign hit = cfg_req_i && (cfg_addr_i == pci_cs_pkg::CFG_DWORD_OFS);
    assign wr  = hit && cfg_we_i;

    // Command readback; unsupported enables are constant zero
    always_comb begin
        cmd_rd = pci_cs_pkg::CTRL_RST; // see [R01] [R02] [R04] [R06]
        cmd_rd[pci_cs_pkg::CTRL_SE_BIT]  = r_q.se;
        cmd_rd[pci_cs_pkg::CTRL_PE_BIT]  = r_q.pe;
        cmd_rd[pci_cs_pkg::CTRL_MWI_BIT] = r_q.mwi;
        cmd_rd[pci_cs_pkg::CTRL_BM_BIT]  = r_q.bm;
        cmd_rd[pci_cs_pkg::CTRL_MEM_BIT] = r_q.mem; // see [R08] [R11]
    end

    // Status readback from the sticky flags and fixed fields
    always_comb begin
        stat_rd = pci_cs_pkg::STAT_RST;
        stat_rd[pci_cs_pkg::STAT_DEVSEL_LSB +: 2] =
            pci_cs_pkg::DEVSEL_MEDIUM; // see [R17]
        stat_rd[pci_cs_pkg::STAT_66M_BIT] = 1'b0; // see [R19]
        stat_rd[pci_cs_pkg::STAT_CAP_BIT] = CAP_LIST; // see [R20]
        stat_rd[pci_cs_pkg::STAT_DPE_BIT] = flags[pci_cs_pkg::FLG_DPE];
        stat_rd[pci_cs_pkg::STAT_SSE_BIT] = flags[pci_cs_pkg::FLG_SSE];
        stat_rd[pci_cs_pkg::STAT_RMA_BIT] = flags[pci_cs_pkg::FLG_RMA];
        stat_rd[pci_cs_pkg::STAT_RTA_BIT] = flags[pci_cs_pkg::FLG_RTA];
        stat_rd[pci_cs_pkg::STAT_STA_BIT] = flags[pci_cs_pkg::FLG_STA];
        stat_rd[pci_cs_pkg::STAT_MDP_BIT] = flags[pci_cs_pkg::FLG_MDP];
    end

    // Writable command lanes and write-one-to-clear status lanes
    assign ctrl_lane = pci_cs_pkg::CTRL_WMASK
                     & {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}}; // see [R01]
    assign clr16 = (wr ? cfg_wdata_i[31:16] : 16'h0000)
                 & pci_cs_pkg::STAT_W1C_MASK
                 & {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}}; // see [R21]

    // Error pin triggers, each gated by its enable
    assign serr_fire = r_q.se && addr_parity_err_i; // see [R03]
    assign perr_fire = r_q.pe
                    && (data_parity_err_i || master_rd_parity_i); // see [R05]

    // Flag events; detected parity ignores the response enable
    always_comb begin
        flag_set = '0;
        flag_set[pci_cs_pkg::FLG_DPE] = addr_parity_err_i
            || data_parity_err_i || master_rd_parity_i; // see [R12]
        flag_set[pci_cs_pkg::FLG_SSE] = serr_fire; // see [R13]
        flag_set[pci_cs_pkg::FLG_RMA] =
            master_abort_i && !special_cycle_i; // see [R14]
        flag_set[pci_cs_pkg::FLG_RTA] = target_abort_rcvd_i; // see [R15]
        flag_set[pci_cs_pkg::FLG_STA] = target_abort_sig_i; // see [R16]
        flag_set[pci_cs_pkg::FLG_MDP] = r_q.bm && r_q.pe
            && (master_rd_parity_i || master_perr_seen_i); // see [R18]
        flag_clr = '0;
        flag_clr[pci_cs_pkg::FLG_DPE] = clr16[pci_cs_pkg::STAT_DPE_BIT];
        flag_clr[pci_cs_pkg::FLG_SSE] = clr16[pci_cs_pkg::STAT_SSE_BIT];
        flag_clr[pci_cs_pkg::FLG_RMA] = clr16[pci_cs_pkg::STAT_RMA_BIT];
        flag_clr[pci_cs_pkg::FLG_RTA] = clr16[pci_cs_pkg::STAT_RTA_BIT];
        flag_clr[pci_cs_pkg::FLG_STA] = clr16[pci_cs_pkg::STAT_STA_BIT];
        flag_clr[pci_cs_pkg::FLG_MDP] = clr16[pci_cs_pkg::STAT_MDP_BIT];
    end

    sticky_event_flags #(
        .N (pci_cs_pkg::NUM_FLAGS)
    ) u_flags (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .set_i    (flag_set),
        .clr_i    (flag_clr),
        .flag_o   (flags)
    );

    // Next state: command writes, readback, gating and pin drive
    always_comb begin
        r_d = r_q;
        if (wr) begin
            r_d.se  = ctrl_lane[pci_cs_pkg::CTRL_SE_BIT]
                    ? cfg_wdata_i[pci_cs_pkg::CTRL_SE_BIT] : r_q.se;
            r_d.pe  = ctrl_lane[pci_cs_pkg::CTRL_PE_BIT]
                    ? cfg_wdata_i[pci_cs_pkg::CTRL_PE_BIT] : r_q.pe;
            r_d.mwi = ctrl_lane[pci_cs_pkg::CTRL_MWI_BIT]
                    ? cfg_wdata_i[pci_cs_pkg::CTRL_MWI_BIT] : r_q.mwi;
            r_d.bm  = ctrl_lane[pci_cs_pkg::CTRL_BM_BIT]
                    ? cfg_wdata_i[pci_cs_pkg::CTRL_BM_BIT] : r_q.bm;
            r_d.mem = ctrl_lane[pci_cs_pkg::CTRL_MEM_BIT]
                    ? cfg_wdata_i[pci_cs_pkg::CTRL_MEM_BIT] : r_q.mem;
        end
        // Every access is answered; unmapped reads and writes give zero
        r_d.ack   = cfg_req_i;
        r_d.rdata = (hit && !cfg_we_i) ? {stat_rd, cmd_rd} : 32'h0000_0000;
        r_d.serr_oe = serr_fire; // see [R03]
        r_d.perr_oe = perr_fire; // see [R05]
        // Gating uses the current enable; a write lands one cycle later
        r_d.mclaim = r_q.mem && mem_hit_i; // see [R10]
        r_d.mreq   = r_q.bm && master_req_i; // see [R09]
        r_d.wcmd   = r_q.mwi ? pci_cs_pkg::CMD_MEM_WR_INV
                             : pci_cs_pkg::CMD_MEM_WRITE; // see [R07]
    end

    // Single register stage for all state except the sticky flags held in u_flags
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            r_q       <= '0;
            r_q.wcmd  <= pci_cs_pkg::CMD_MEM_WRITE;
        end else begin
            r_q <= r_d;
        end
    end

    // Outputs; error pins only ever pull low when enabled
    assign cfg_ack_o               = r_q.ack;
    assign cfg_rdata_o             = r_q.rdata;
    assign master_req_o            = r_q.mreq;
    assign master_write_cmd_o      = r_q.wcmd;
    assign mem_claim_o             = r_q.mclaim;
    assign bus_master_enable_o     = r_q.bm;
    assign system_error_pin_n_o    = !r_q.serr_oe;
    assign system_error_pin_n_oe_o = r_q.serr_oe;
    assign parity_error_pin_n_o    = !r_q.perr_oe;
    assign parity_error_pin_n_oe_o = r_q.perr_oe;

    // Checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);

    logic rd_hit_q;

    // Marks answers that carry real readback
    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            rd_hit_q <= 1'b0;
        end else begin
            rd_hit_q <= hit && !cfg_we_i;
        end
    end

    property p_cmd_rsvd;
        cfg_ack_o |-> cfg_rdata_o[15:10] == 6'h00;
    endproperty
    a_cmd_rsvd: assert property (p_cmd_rsvd) // see [R01]
        else $error("reserved command bits read nonzero");

    property p_fbb_zero;
        cfg_ack_o |-> !cfg_rdata_o[pci_cs_pkg::CTRL_FBB_BIT];
    endproperty
    a_fbb_zero: assert property (p_fbb_zero) // see [R02]
        else $error("back-to-back enable read as one");

    property p_serr_gate;
        system_error_pin_n_oe_o |->
            $past(r_q.se) && $past(addr_parity_err_i)
            && !system_error_pin_n_o;
    endproperty
    a_serr_gate: assert property (p_serr_gate) // see [R03]
        else $error("system error pin driven without cause");

    property p_step_zero;
        cfg_ack_o |-> !cfg_rdata_o[pci_cs_pkg::CTRL_STEP_BIT];
    endproperty
    a_step_zero: assert property (p_step_zero) // see [R04]
        else $error("stepping control read as one");

    property p_perr_gate;
        parity_error_pin_n_oe_o |-> $past(r_q.pe)
            && ($past(data_parity_err_i) || $past(master_rd_parity_i));
    endproperty
    a_perr_gate: assert property (p_perr_gate) // see [R05]
        else $error("parity pin driven without cause");

    property p_hardwired_zero;
        cfg_ack_o |-> !cfg_rdata_o[pci_cs_pkg::CTRL_VGA_BIT]
            && !cfg_rdata_o[pci_cs_pkg::CTRL_SPC_BIT]
            && !cfg_rdata_o[pci_cs_pkg::CTRL_IO_BIT]
            && !cfg_rdata_o[16 + pci_cs_pkg::STAT_66M_BIT];
    endproperty
    a_hardwired_zero: assert property (p_hardwired_zero) // see [R06]
        else $error("hardwired zero bit read as one");

    property p_wcmd;
        ##1 master_write_cmd_o == ($past(r_q.mwi)
            ? pci_cs_pkg::CMD_MEM_WR_INV : pci_cs_pkg::CMD_MEM_WRITE);
    endproperty
    a_wcmd: assert property (p_wcmd) // see [R07]
        else $error("master write command does not follow enable");

    property p_mreq_gate;
        master_req_o |-> $past(r_q.bm) && $past(master_req_i);
    endproperty
    a_mreq_gate: assert property (p_mreq_gate) // see [R09]
        else $error("master request while master disabled");

    property p_claim_gate;
        mem_hit_i && r_q.mem |=> mem_claim_o;
    endproperty
    a_claim_gate: assert property (p_claim_gate) // see [R10]
        else $error("enabled memory hit not claimed");

    property p_noclaim;
        !r_q.mem |=> !mem_claim_o;
    endproperty
    a_noclaim: assert property (p_noclaim) // see [R10]
        else $error("memory claimed while response disabled");

    property p_dpe_set;
        data_parity_err_i |=> flags[pci_cs_pkg::FLG_DPE];
    endproperty
    a_dpe_set: assert property (p_dpe_set) // see [R12]
        else $error("detected parity flag not set");

    property p_sse_set;
        system_error_pin_n_oe_o |-> flags[pci_cs_pkg::FLG_SSE];
    endproperty
    a_sse_set: assert property (p_sse_set) // see [R13]
        else $error("system error flag missing with pin driven");

    property p_rma_set;
        master_abort_i && !special_cycle_i |=> flags[pci_cs_pkg::FLG_RMA];
    endproperty
    a_rma_set: assert property (p_rma_set) // see [R14]
        else $error("master abort flag not set");

    property p_rta_sta;
        target_abort_rcvd_i && target_abort_sig_i |=>
            flags[pci_cs_pkg::FLG_RTA] && flags[pci_cs_pkg::FLG_STA];
    endproperty
    a_rta_sta: assert property (p_rta_sta) // see [R15] [R16]
        else $error("target abort flags not set");

    property p_devsel;
        rd_hit_q |-> cfg_rdata_o[26:25] == pci_cs_pkg::DEVSEL_MEDIUM
            && cfg_rdata_o[16 + pci_cs_pkg::STAT_CAP_BIT] == CAP_LIST;
    endproperty
    a_devsel: assert property (p_devsel) // see [R17] [R20]
        else $error("fixed status fields wrong");

    property p_mdp_set;
        r_q.bm && r_q.pe && master_perr_seen_i
            |=> flags[pci_cs_pkg::FLG_MDP];
    endproperty
    a_mdp_set: assert property (p_mdp_set) // see [R18]
        else $error("master data parity flag not set");

    property p_flag_hold;
        flags[pci_cs_pkg::FLG_RMA]
            && !clr16[pci_cs_pkg::STAT_RMA_BIT] |=>
            flags[pci_cs_pkg::FLG_RMA];
    endproperty
    a_flag_hold: assert property (p_flag_hold) // see [R21]
        else $error("sticky flag lost without a clear");

    c_serr: cover property (system_error_pin_n_oe_o);
    c_clear: cover property (flags[pci_cs_pkg::FLG_DPE] ##1
        !flags[pci_cs_pkg::FLG_DPE]);
    c_claim: cover property (wr ##1 mem_claim_o);
    c_mwi: cover property (master_req_o
        && master_write_cmd_o == pci_cs_pkg::CMD_MEM_WR_INV);

endmodule

// file: pci_cs_pkg.sv
// Offsets, field positions and reset values of the command/status words
package pci_cs_pkg;

    // Configuration dword holding both words, and the printed word offsets
    localparam logic [7:0]  CFG_DWORD_OFS   = 8'h04;
    localparam logic [7:0]  CTRL_OFS        = 8'h04;
    localparam logic [7:0]  STAT_OFS        = 8'h06;

    // Command word field positions
    localparam int          CTRL_IO_BIT     = 0;
    localparam int          CTRL_MEM_BIT    = 1;
    localparam int          CTRL_BM_BIT     = 2;
    localparam int          CTRL_SPC_BIT    = 3;
    localparam int          CTRL_MWI_BIT    = 4;
    localparam int          CTRL_VGA_BIT    = 5;
    localparam int          CTRL_PE_BIT     = 6;
    localparam int          CTRL_STEP_BIT   = 7;
    localparam int          CTRL_SE_BIT     = 8;
    localparam int          CTRL_FBB_BIT    = 9;
    localparam int          CTRL_RSVD_LSB   = 10;

    // Status word field positions
    localparam int          STAT_CAP_BIT    = 4;
    localparam int          STAT_66M_BIT    = 5;
    localparam int          STAT_FBBC_BIT   = 7;
    localparam int          STAT_MDP_BIT    = 8;
    localparam int          STAT_DEVSEL_LSB = 9;
    localparam int          STAT_STA_BIT    = 11;
    localparam int          STAT_RTA_BIT    = 12;
    localparam int          STAT_RMA_BIT    = 13;
    localparam int          STAT_SSE_BIT    = 14;
    localparam int          STAT_DPE_BIT    = 15;

    // Values after reset, fixed field values and write masks
    localparam logic [15:0] CTRL_RST        = 16'h0000;
    localparam logic [15:0] STAT_RST        = 16'h0290;
    localparam logic [1:0]  DEVSEL_MEDIUM   = 2'h1;
    localparam logic [15:0] CTRL_WMASK      = 16'h0156;
    localparam logic [15:0] STAT_W1C_MASK   = 16'hF900;

    // Sticky flag indices
    localparam int          NUM_FLAGS       = 6;
    localparam int          FLG_MDP         = 0;
    localparam int          FLG_STA         = 1;
    localparam int          FLG_RTA         = 2;
    localparam int          FLG_RMA         = 3;
    localparam int          FLG_SSE         = 4;
    localparam int          FLG_DPE         = 5;

    // Master write command codes
    localparam logic [3:0]  CMD_MEM_WRITE   = 4'h7;
    localparam logic [3:0]  CMD_MEM_WR_INV  = 4'hF;

endpackage

// file: sticky_event_flags.sv
// Set-dominant sticky event flags with per-bit clear
`timescale 1ns/1ps

module sticky_event_flags #(
    parameter int N = 6
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         resetn_i,
    // Events and clears
    input  wire logic [N-1:0] set_i,
    input  wire logic [N-1:0] clr_i,
    // Flag state
    output logic      [N-1:0] flag_o
);

    typedef struct packed {
        logic [N-1:0] flag;
    } flag_state_t;

    flag_state_t st_q;
    flag_state_t st_d;

    if (N < 1) begin : g_bad_n
        $error("sticky_event_flags needs at least one flag");
    end

    // Set wins over a clear in the same cycle, so no event is lost
    always_comb begin
        st_d = st_q;
        for (int i = 0; i < N; i++) begin
            st_d.flag[i] = set_i[i] | (st_q.flag[i] & ~clr_i[i]);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flag_o = st_q.flag;

endmodule

// file: testbench.sv
// Self-checking bench for the command and status words
`timescale 1ns/1ps

module testbench;
    typedef struct packed {
        logic [3:0]  be;
        logic [31:0] wdata;
        logic [7:0]  ev;
        logic [31:0] exp;
        logic [1:0]  low;
    } row_t;

    logic        mclk_i   = 1'b0;
    logic        resetn_i = 1'b0;
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic        ack;
    logic [7:0]  ev       = 8'h00;
    logic        mreq_i   = 1'b0;
    logic        hit      = 1'b0;
    logic        mreq_o;
    logic        claim;
    logic        bme;
    logic [3:0]  wcmd;
    logic        serr_pin;
    logic        serr_oe;
    logic        perr_pin;
    logic        perr_oe;
    wire         serr_w;
    wire         perr_w;
    int          comparisons = 0;
    int          fails       = 0;

    // Event bits: addr par, data par, rd par, perr seen, abort, special, tar, tas
    row_t rows [16] = '{
        '{4'hF, 32'hFFFF_FFFF, 8'h00, 32'h0290_0156, 2'h0},
        '{4'hF, 32'h0000_0000, 8'h00, 32'h0290_0000, 2'h0},
        '{4'h1, 32'h0000_FFFF, 8'h00, 32'h0290_0056, 2'h0},
        '{4'h2, 32'h0000_FF00, 8'h00, 32'h0290_0156, 2'h0},
        '{4'hC, 32'hFFFF_0000, 8'h00, 32'h0290_0156, 2'h0},
        '{4'hF, 32'h0000_0000, 8'h80, 32'h8290_0000, 2'h0},
        '{4'hF, 32'h0000_0100, 8'h80, 32'hC290_0100, 2'h2},
        '{4'hF, 32'h0000_0040, 8'h40, 32'h8290_0040, 2'h1},
        '{4'hF, 32'h0000_0000, 8'h40, 32'h8290_0000, 2'h0},
        '{4'hF, 32'h0000_0044, 8'h20, 32'h8390_0044, 2'h1},
        '{4'hF, 32'h0000_0044, 8'h10, 32'h0390_0044, 2'h0},
        '{4'hF, 32'h0000_0004, 8'h20, 32'h8290_0004, 2'h0},
        '{4'hF, 32'h0000_0000, 8'h08, 32'h2290_0000, 2'h0},
        '{4'hF, 32'h0000_0000, 8'h0C, 32'h0290_0000, 2'h0},
        '{4'hF, 32'h0000_0000, 8'h02, 32'h1290_0000, 2'h0},
        '{4'hF, 32'h0000_0000, 8'h01, 32'h0A90_0000, 2'h0}
    };
    // Gating cases; memory hits start while memory enable is still clear
    logic [15:0] gcmd [4] = '{16'h0000, 16'h0002, 16'h0004, 16'h0016};

    // Open-drain pins idle high through their pull-ups
    assign serr_w = serr_oe ? serr_pin : 1'b1;
    assign perr_w = perr_oe ? perr_pin : 1'b1;

    always #50 mclk_i = ~mclk_i;

    pci_command_status_regs #(.CAP_LIST(1'b1)) i_dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i),
        .cfg_req_i(req), .cfg_we_i(we), .cfg_addr_i(addr), .cfg_be_i(be),
        .cfg_wdata_i(wdata), .cfg_ack_o(ack), .cfg_rdata_o(rdata),
        .addr_parity_err_i(ev[7]), .data_parity_err_i(ev[6]),
        .master_rd_parity_i(ev[5]), .master_perr_seen_i(ev[4]),
        .master_abort_i(ev[3]), .special_cycle_i(ev[2]),
        .target_abort_rcvd_i(ev[1]), .target_abort_sig_i(ev[0]),
        .master_req_i(mreq_i), .mem_hit_i(hit), .master_req_o(mreq_o),
        .master_write_cmd_o(wcmd), .mem_claim_o(claim),
        .bus_master_enable_o(bme),
        .system_error_pin_n_o(serr_pin), .system_error_pin_n_oe_o(serr_oe),
        .parity_error_pin_n_o(perr_pin), .parity_error_pin_n_oe_o(perr_oe)
    );

    host_cfg_model i_host (
        .mclk_i(mclk_i), .cfg_req_o(req), .cfg_we_o(we), .cfg_addr_o(addr),
        .cfg_be_o(be), .cfg_wdata_o(wdata), .cfg_ack_i(ack),
        .cfg_rdata_i(rdata)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // A lost answer ends the run at once
    task automatic cfg(input logic w, input logic [7:0] a,
                       input logic [3:0] b, input logic [31:0] d);
        logic ok;
        i_host.access(w, a, b, d, rd, ok);
        if (!ok) begin
            fails++;
            conclude();
        end
    endtask

    // Pulse events, then watch the pins for exactly one low cycle
    task automatic pulse(input logic [7:0] e, input logic [1:0] low);
        @(posedge mclk_i);
        #1 ev = e;
        @(posedge mclk_i);
        #1 ev = 8'h00;
        check({30'h0, ~serr_w, ~perr_w}, {30'h0, low});
        @(posedge mclk_i);
        #1;
        check({30'h0, ~serr_w, ~perr_w}, 32'h0);
    endtask

    function automatic logic [6:0] gate_exp(input logic [15:0] c);
        logic bm;
        bm = c[pci_cs_pkg::CTRL_BM_BIT];
        return {bm, c[pci_cs_pkg::CTRL_MEM_BIT], bm,
                c[pci_cs_pkg::CTRL_MWI_BIT] ? 4'hF : 4'h7};
    endfunction

    initial begin
        repeat (20) @(posedge mclk_i);
        #1 resetn_i = 1'b1;
        // Write, fire events, read back, then clear every flag by one
        foreach (rows[i]) begin
            cfg(1'b1, pci_cs_pkg::CFG_DWORD_OFS, rows[i].be, rows[i].wdata);
            pulse(rows[i].ev, rows[i].low);
            cfg(1'b0, pci_cs_pkg::CFG_DWORD_OFS, 4'hF, 32'h0);
            check(rd, rows[i].exp);
            cfg(1'b1, pci_cs_pkg::CFG_DWORD_OFS, 4'hC, 32'hF900_0000);
        end
        // Enables gate requests, claims and the write command
        mreq_i = 1'b1;
        hit = 1'b1;
        foreach (gcmd[i]) begin
            cfg(1'b1, pci_cs_pkg::CFG_DWORD_OFS, 4'hF, {16'h0, gcmd[i]});
            @(posedge mclk_i);
            #1;
            check({25'h0, mreq_o, claim, bme, wcmd},
                  {25'h0, gate_exp(gcmd[i])});
        end
        // A clear meeting a fresh event at one edge must lose
        cfg(1'b1, pci_cs_pkg::CFG_DWORD_OFS, 4'hF, 32'h0);
        pulse(8'h02, 2'h0);
        fork
            cfg(1'b1, pci_cs_pkg::CFG_DWORD_OFS, 4'hC, 32'hF900_0000);
            begin
                @(posedge mclk_i);
                #1 ev = 8'h02;
                @(posedge mclk_i);
                #1 ev = 8'h00;
            end
        join
        // Unmapped dword: write ignored, read gives zero
        cfg(1'b1, 8'h08, 4'hF, 32'hFFFF_FFFF);
        cfg(1'b0, pci_cs_pkg::CFG_DWORD_OFS, 4'hF, 32'h0);
        check(rd, 32'h1290_0000);
        cfg(1'b0, 8'h08, 4'hF, 32'h0);
        check(rd, 32'h0000_0000);
        // Second reset in mid-run with enables and requests active
        cfg(1'b1, pci_cs_pkg::CFG_DWORD_OFS, 4'hF, 32'hFFFF_FFFF);
        resetn_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1 resetn_i = 1'b1;
        check({25'h0, mreq_o, claim, bme, wcmd}, 32'h0000_0007);
        cfg(1'b0, pci_cs_pkg::CFG_DWORD_OFS, 4'hF, 32'h0);
        check(rd, 32'h0290_0000);
        conclude();
    end
endmodule
